//--- mmp_pkg.sv
// package: constants for the memory map and port slice
package mmp_pkg;
   localparam int unsigned CLOCK_HZ = 20000000;
   localparam int unsigned MACHINE_CYCLE_NS = 750;
   localparam int unsigned CLOCK_NS = 50;
   localparam int unsigned MACHINE_CYCLE_CLKS = MACHINE_CYCLE_NS / CLOCK_NS;
   localparam int unsigned STRONG_PULLUP_NS = MACHINE_CYCLE_NS / 5;
   localparam int unsigned STRONG_PULLUP_CLKS_RAW = STRONG_PULLUP_NS / CLOCK_NS;
   localparam int unsigned STRONG_PULLUP_CLKS = (STRONG_PULLUP_CLKS_RAW < 1) ? 1 : STRONG_PULLUP_CLKS_RAW;
   localparam int unsigned STROBE_CLKS = 2;
   localparam logic [11:0] RESET_VECTOR = 12'h000;
   localparam logic [11:0] EXT_INT_VECTOR = 12'h003;
   localparam logic [11:0] TIMER_INT_VECTOR = 12'h007;
   localparam logic [7:0] POINTER_A_ADDR = 8'h00;
   localparam logic [7:0] POINTER_B_ADDR = 8'h01;
   localparam logic [7:0] BANK0_BASE = 8'h00;
   localparam logic [7:0] BANK1_BASE = 8'h18;
   localparam logic [7:0] STACK_BASE = 8'h08;
   localparam int unsigned STATUS_BANK_BIT = 4;
   localparam int unsigned STATUS_CARRY_BIT = 7;
   localparam int unsigned STATUS_AUX_BIT = 6;
   localparam int unsigned STATUS_UNUSED_BIT = 3;
   localparam logic [7:0] STATUS_RESET = 8'h08;
   localparam logic [7:0] PORT_RESET = 8'hff;
   localparam logic [10:0] UPPER_BANK_OFFSET = 11'h000;
   typedef enum logic [3:0] {
      MMP_ALU_ADD, MMP_ALU_ADDC, MMP_ALU_AND, MMP_ALU_OR, MMP_ALU_XOR, MMP_ALU_INC,
      MMP_ALU_DEC, MMP_ALU_CPL, MMP_ALU_RL, MMP_ALU_RR, MMP_ALU_SWAP, MMP_ALU_DA, MMP_ALU_PASS
   } mmp_alu_t;
   typedef enum logic [3:0] {
      MMP_OP_NONE, MMP_OP_ALU, MMP_OP_CALL, MMP_OP_RET, MMP_OP_RETR, MMP_OP_JUMP,
      MMP_OP_SELECT_MB, MMP_OP_SELECT_BANK, MMP_OP_PORT_WRITE, MMP_OP_PORT_OR,
      MMP_OP_PORT_AND, MMP_OP_PORT_READ, MMP_OP_BUS_WRITE, MMP_OP_BUS_READ,
      MMP_OP_EXT_WRITE, MMP_OP_EXT_READ
   } mmp_op_t;
   typedef enum logic [2:0] {
      MMP_MEM_NONE, MMP_MEM_WORK_RD, MMP_MEM_WORK_WR, MMP_MEM_IND_RD, MMP_MEM_IND_WR, MMP_MEM_TABLE
   } mmp_mem_t;
endpackage

//--- mmp_core.sv
// module: program counter, data memory map, arithmetic unit and ports
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module mmp_core #(
   parameter int unsigned PROG_WORDS = 4096,
   parameter int unsigned DATA_BYTES = 256
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire mmp_pkg::mmp_op_t i_op,
   input wire logic i_op_valid,
   input wire mmp_pkg::mmp_alu_t i_alu_fn,
   input wire logic [7:0] i_operand,
   input wire logic [11:0] i_target,
   input wire logic i_select_value,
   input wire logic i_port_sel,
   input wire mmp_pkg::mmp_mem_t i_mem_op,
   input wire logic [2:0] i_mem_index,
   input wire logic i_ptr_sel,
   input wire logic i_int_enable,
   input wire logic i_timer_int_enable,
   input wire logic i_ext_int_n,
   input wire logic i_timer_overflow,
   input wire logic [7:0] i_status_write,
   input wire logic i_status_write_en,
   input wire logic [7:0] i_prog_load_data,
   input wire logic [11:0] i_prog_load_addr,
   input wire logic i_prog_load_en,
   input wire logic [7:0] i_port_a_in,
   output logic [7:0] o_port_a_out,
   output logic [7:0] o_port_a_strong,
   input wire logic [7:0] i_port_b_in,
   output logic [7:0] o_port_b_out,
   output logic [7:0] o_port_b_strong,
   input wire logic [7:0] i_bus_in,
   output logic [7:0] o_bus_out,
   output logic o_bus_oe,
   output logic o_bus_rd_n,
   output logic o_bus_wr_n,
   input wire logic i_test_input_a,
   input wire logic i_test_input_b,
   output logic o_test_a,
   output logic o_test_b,
   output logic o_ext_int_level,
   output logic [7:0] o_acc,
   output logic [7:0] o_status,
   output logic [11:0] o_pc,
   output logic [7:0] o_mem_data,
   output logic [7:0] o_table_data,
   output logic o_int_active
);
   import mmp_pkg::*;
   if (!(PROG_WORDS == 1024 || PROG_WORDS == 2048 || PROG_WORDS == 4096))
      $error("program memory size not supported");
   if (!(DATA_BYTES == 64 || DATA_BYTES == 128 || DATA_BYTES == 256))
      $error("data memory size not supported");
   localparam int PAW = $clog2(PROG_WORDS);
   localparam int DAW = $clog2(DATA_BYTES);

   //////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [7:0] pa_s1_q, pa_s2_q, pb_s1_q, pb_s2_q, bus_s1_q, bus_s2_q;
   logic [2:0] tst_s1_q, tst_s2_q;
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         pa_s1_q <= 8'hff;
         pa_s2_q <= 8'hff;
         pb_s1_q <= 8'hff;
         pb_s2_q <= 8'hff;
         bus_s1_q <= 8'h00;
         bus_s2_q <= 8'h00;
         tst_s1_q <= 3'h7;
         tst_s2_q <= 3'h7;
      end
      else
      begin
         pa_s1_q <= i_port_a_in;
         pa_s2_q <= pa_s1_q;
         pb_s1_q <= i_port_b_in;
         pb_s2_q <= pb_s1_q;
         bus_s1_q <= i_bus_in;
         bus_s2_q <= bus_s1_q;
         tst_s1_q <= {i_ext_int_n, i_test_input_b, i_test_input_a};
         tst_s2_q <= tst_s1_q;
      end
   end
   assign o_test_a = tst_s2_q[0];
   assign o_test_b = tst_s2_q[1];
   assign o_ext_int_level = ~tst_s2_q[2];

   //////////////////////////////////////////////////////////////////////////
   // status word and arithmetic unit
   logic [7:0] acc_q, status_q;
   logic [8:0] alu_sum;
   logic [7:0] alu_res;
   logic alu_cy, alu_ac;
   always_comb
   begin
      alu_sum = 9'h000;
      alu_res = acc_q;
      alu_cy = status_q[STATUS_CARRY_BIT];
      alu_ac = status_q[STATUS_AUX_BIT];
      case (i_alu_fn)
         MMP_ALU_ADD, MMP_ALU_ADDC:
         begin
            alu_sum = {1'b0, acc_q} + {1'b0, i_operand}
               + {8'h00, (i_alu_fn == MMP_ALU_ADDC) & status_q[STATUS_CARRY_BIT]};
            alu_res = alu_sum[7:0];
            alu_cy = alu_sum[8];
            alu_ac = alu_sum[4] ^ acc_q[4] ^ i_operand[4];
         end
         MMP_ALU_AND: alu_res = acc_q & i_operand;
         MMP_ALU_OR: alu_res = acc_q | i_operand;
         MMP_ALU_XOR: alu_res = acc_q ^ i_operand;
         MMP_ALU_INC: alu_res = acc_q + 8'h01;
         MMP_ALU_DEC: alu_res = acc_q - 8'h01;
         MMP_ALU_CPL: alu_res = ~acc_q;
         MMP_ALU_RL: alu_res = {acc_q[6:0], acc_q[7]};
         MMP_ALU_RR: alu_res = {acc_q[0], acc_q[7:1]};
         MMP_ALU_SWAP: alu_res = {acc_q[3:0], acc_q[7:4]};
         MMP_ALU_DA:
         begin
            alu_sum = {1'b0, acc_q};
            if (acc_q[3:0] > 4'h9 || status_q[STATUS_AUX_BIT])
               alu_sum = alu_sum + 9'h006;
            if (alu_sum[7:4] > 4'h9 || alu_sum[8] || status_q[STATUS_CARRY_BIT])
               alu_sum = alu_sum + 9'h060;
            alu_res = alu_sum[7:0];
            alu_cy = alu_sum[8] | status_q[STATUS_CARRY_BIT];
         end
         MMP_ALU_PASS: alu_res = i_operand;
         default: alu_res = acc_q;
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   // program counter, stack and interrupts
   logic [11:0] pc_q;
   logic mb_q, mb_pend_q, int_busy_q;
   logic [2:0] sp_q;
   logic [7:0] prog_mem_q [PROG_WORDS];
   logic [7:0] data_mem_q [DATA_BYTES];
   logic take_ext, take_tmr, is_call, is_ret;
   logic [11:0] call_target, ret_pc;
   logic [DAW-1:0] push_addr, pop_addr;
   assign take_ext = i_int_enable & ~int_busy_q & ~tst_s2_q[2];
   assign take_tmr = i_timer_int_enable & ~int_busy_q & i_timer_overflow & ~take_ext;
   assign is_call = (i_op_valid && i_op == MMP_OP_CALL) || take_ext || take_tmr;
   assign is_ret = i_op_valid && (i_op == MMP_OP_RET || i_op == MMP_OP_RETR);
   always_comb
   begin
      call_target = {mb_q, i_target[10:0]};
      if (take_ext)
         call_target = EXT_INT_VECTOR;
      else if (take_tmr)
         call_target = TIMER_INT_VECTOR;
   end
   assign push_addr = DAW'(STACK_BASE + {4'h0, sp_q, 1'b0});
   assign pop_addr = DAW'(STACK_BASE + {4'h0, sp_q - 3'h1, 1'b0});
   assign ret_pc = {data_mem_q[DAW'(pop_addr + 1'b1)][3:0], data_mem_q[pop_addr]};
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         pc_q <= RESET_VECTOR;
         sp_q <= 3'h0;
         mb_q <= 1'b0;
         mb_pend_q <= 1'b0;
         int_busy_q <= 1'b0;
      end
      else
      begin
         if (i_op_valid && i_op == MMP_OP_SELECT_MB)
            mb_pend_q <= i_select_value;
         if (is_call)
         begin
            pc_q <= call_target & 12'(PROG_WORDS - 1);
            sp_q <= sp_q + 3'h1;
            if (take_ext || take_tmr)
               int_busy_q <= 1'b1;
         end
         else if (is_ret)
         begin
            pc_q <= ret_pc;
            sp_q <= sp_q - 3'h1;
            mb_q <= ret_pc[11];
            if (i_op == MMP_OP_RETR)
               int_busy_q <= 1'b0;
         end
         else if (i_op_valid && i_op == MMP_OP_JUMP)
         begin
            pc_q <= {mb_pend_q, i_target[10:0]} & 12'(PROG_WORDS - 1);
            mb_q <= mb_pend_q;
         end
         else if (i_op_valid)
            pc_q <= {pc_q[11], pc_q[10:0] + 11'h001} & 12'(PROG_WORDS - 1);
         if (is_call && !(take_ext || take_tmr))
            mb_q <= mb_pend_q;
      end
   end
   assign o_pc = pc_q;
   assign o_int_active = int_busy_q;

   //////////////////////////////////////////////////////////////////////////
   // data memory with banked working registers and stack
   logic [DAW-1:0] work_addr, ind_addr;
   logic bank;
   assign bank = status_q[STATUS_BANK_BIT];
   assign work_addr = DAW'((bank ? BANK1_BASE : BANK0_BASE) + {5'h00, i_mem_index});
   assign ind_addr = DAW'(data_mem_q[DAW'((bank ? BANK1_BASE : BANK0_BASE) + {7'h00, i_ptr_sel})]);
   always_ff @(posedge i_clock)
   begin
      if (i_op_valid && i_mem_op == MMP_MEM_WORK_WR)
         data_mem_q[work_addr] <= acc_q;
      else if (i_op_valid && i_mem_op == MMP_MEM_IND_WR)
         data_mem_q[ind_addr] <= acc_q;
      if (is_call)
      begin
         data_mem_q[push_addr] <= pc_q[7:0];
         data_mem_q[DAW'(push_addr + 1'b1)] <= {status_q[7:4], pc_q[11:8]};
      end
   end
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         o_mem_data <= 8'h00;
      else if (i_op_valid && i_mem_op == MMP_MEM_WORK_RD)
         o_mem_data <= data_mem_q[work_addr];
      else if (i_op_valid && i_mem_op == MMP_MEM_IND_RD)
         o_mem_data <= data_mem_q[ind_addr];
   end

   //////////////////////////////////////////////////////////////////////////
   // program memory, table reads
   always_ff @(posedge i_clock)
   begin
      if (i_prog_load_en)
         prog_mem_q[i_prog_load_addr[PAW-1:0]] <= i_prog_load_data;
   end
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         o_table_data <= 8'h00;
      else if (i_op_valid && i_mem_op == MMP_MEM_TABLE)
         o_table_data <= prog_mem_q[{pc_q[PAW-1:8], acc_q}];
   end

   //////////////////////////////////////////////////////////////////////////
   // accumulator and status
   logic [7:0] port_val;
   logic bus_rd_done_q;
   assign port_val = i_port_sel ? pb_s2_q : pa_s2_q;
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         acc_q <= 8'h00;
         status_q <= STATUS_RESET;
      end
      else
      begin
         if (i_status_write_en)
            status_q <= i_status_write | 8'h08;
         else if (is_ret && i_op == MMP_OP_RETR)
            status_q[7:4] <= data_mem_q[DAW'(pop_addr + 1'b1)][7:4];
         else if (i_op_valid && i_op == MMP_OP_SELECT_BANK)
            status_q[STATUS_BANK_BIT] <= i_select_value;
         else if (i_op_valid && i_op == MMP_OP_ALU)
         begin
            status_q[STATUS_CARRY_BIT] <= alu_cy;
            status_q[STATUS_AUX_BIT] <= alu_ac;
         end
         if (i_op_valid && i_op == MMP_OP_ALU)
            acc_q <= alu_res;
         else if (i_op_valid && i_op == MMP_OP_PORT_READ)
            acc_q <= port_val;
         else if (bus_rd_done_q)
            acc_q <= bus_s2_q;
      end
   end
   assign o_acc = acc_q;
   assign o_status = {status_q[7:4], 1'b1, sp_q};

   //////////////////////////////////////////////////////////////////////////
   // quasi-bidirectional ports
   logic [7:0] pa_q, pb_q, pa_new, pb_new;
   logic pa_wr, pb_wr;
   logic [7:0] str_cnt_a_q, str_cnt_b_q;
   logic port_op;
   assign port_op = i_op_valid && (i_op == MMP_OP_PORT_WRITE || i_op == MMP_OP_PORT_OR || i_op == MMP_OP_PORT_AND);
   assign pa_wr = port_op && !i_port_sel;
   assign pb_wr = port_op && i_port_sel;
   always_comb
   begin
      pa_new = i_operand;
      pb_new = i_operand;
      if (i_op == MMP_OP_PORT_OR)
      begin
         pa_new = pa_s2_q | i_operand;
         pb_new = pb_s2_q | i_operand;
      end
      else if (i_op == MMP_OP_PORT_AND)
      begin
         pa_new = pa_s2_q & i_operand;
         pb_new = pb_s2_q & i_operand;
      end
   end
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         pa_q <= PORT_RESET;
         pb_q <= PORT_RESET;
         o_port_a_strong <= 8'h00;
         o_port_b_strong <= 8'h00;
         str_cnt_a_q <= 8'h00;
         str_cnt_b_q <= 8'h00;
      end
      else
      begin
         if (pa_wr)
         begin
            pa_q <= pa_new;
            o_port_a_strong <= pa_new;
            str_cnt_a_q <= 8'(STRONG_PULLUP_CLKS);
         end
         else if (str_cnt_a_q > 8'h01)
            str_cnt_a_q <= str_cnt_a_q - 8'h01;
         else
         begin
            str_cnt_a_q <= 8'h00;
            o_port_a_strong <= 8'h00;
         end
         if (pb_wr)
         begin
            pb_q <= pb_new;
            o_port_b_strong <= pb_new;
            str_cnt_b_q <= 8'(STRONG_PULLUP_CLKS);
         end
         else if (str_cnt_b_q > 8'h01)
            str_cnt_b_q <= str_cnt_b_q - 8'h01;
         else
         begin
            str_cnt_b_q <= 8'h00;
            o_port_b_strong <= 8'h00;
         end
      end
   end
   assign o_port_a_out = pa_q;
   assign o_port_b_out = pb_q;

   //////////////////////////////////////////////////////////////////////////
   // bus port with strobes
   typedef enum logic [1:0] {MMP_BUS_IDLE, MMP_BUS_WR, MMP_BUS_RD} mmp_bus_t;
   mmp_bus_t bus_st_q;
   logic [7:0] bus_q, bus_cnt_q;
   logic bus_static_q;
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         bus_st_q <= MMP_BUS_IDLE;
         bus_q <= 8'h00;
         bus_cnt_q <= 8'h00;
         bus_static_q <= 1'b0;
         bus_rd_done_q <= 1'b0;
      end
      else
      begin
         bus_rd_done_q <= (bus_st_q == MMP_BUS_RD) && (bus_cnt_q == 8'h01);
         case (bus_st_q)
            MMP_BUS_IDLE:
            begin
               if (i_op_valid && (i_op == MMP_OP_BUS_WRITE || i_op == MMP_OP_EXT_WRITE))
               begin
                  bus_q <= acc_q;
                  bus_static_q <= i_op == MMP_OP_BUS_WRITE;
                  bus_st_q <= MMP_BUS_WR;
                  bus_cnt_q <= 8'(STROBE_CLKS);
               end
               else if (i_op_valid && (i_op == MMP_OP_BUS_READ || i_op == MMP_OP_EXT_READ))
               begin
                  bus_static_q <= 1'b0;
                  bus_st_q <= MMP_BUS_RD;
                  bus_cnt_q <= 8'(STROBE_CLKS);
               end
            end
            default:
            begin
               if (bus_cnt_q <= 8'h01)
                  bus_st_q <= MMP_BUS_IDLE;
               bus_cnt_q <= bus_cnt_q - 8'h01;
            end
         endcase
      end
   end
   assign o_bus_wr_n = ~(bus_st_q == MMP_BUS_WR);
   assign o_bus_rd_n = ~(bus_st_q == MMP_BUS_RD);
   assign o_bus_oe = (bus_st_q == MMP_BUS_WR) || bus_static_q;
   assign o_bus_out = bus_q;
endmodule

//--- mmp_core_monitor.sv
// checker: port-level properties of the core
`timescale 1ns/1ps
module mmp_core_monitor
   import mmp_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire mmp_pkg::mmp_op_t i_op,
   input wire logic i_op_valid,
   input wire mmp_pkg::mmp_alu_t i_alu_fn,
   input wire logic [7:0] i_operand,
   input wire logic i_status_write_en,
   input wire logic i_int_enable,
   input wire logic i_ext_int_n,
   input wire logic i_port_sel,
   input wire logic [7:0] i_port_a_in,
   input wire logic [7:0] o_port_a_out,
   input wire logic [7:0] o_port_a_strong,
   input wire logic [7:0] o_bus_out,
   input wire logic o_bus_oe,
   input wire logic o_bus_rd_n,
   input wire logic o_bus_wr_n,
   input wire logic [7:0] o_acc,
   input wire logic [7:0] o_status,
   input wire logic [11:0] o_pc,
   input wire logic o_int_active
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_rst);
   //////////////////////////////////////////////////////////////////////////////
   property p_rst_state;
      $fell(i_rst) |-> o_pc == RESET_VECTOR && o_port_a_out == PORT_RESET && o_port_a_strong == 8'h00 && !o_bus_oe;
   endproperty
   a_rst_state: assert property (p_rst_state) else $error("state after reset wrong");
   property p_strong_one;
      (o_port_a_strong & ~o_port_a_out) == 8'h00;
   endproperty
   a_strong_one: assert property (p_strong_one) else $error("strong pull-up on a low line");
   property p_strong_len;
      $rose(|o_port_a_strong) |-> (|o_port_a_strong) [*3] ##1 !(|o_port_a_strong);
   endproperty
   a_strong_len: assert property (p_strong_len) else $error("strong pull-up length wrong");
   property p_wr_pulse;
      $fell(o_bus_wr_n) |-> o_bus_oe ##1 (!o_bus_wr_n && o_bus_oe && $stable(o_bus_out)) ##1 o_bus_wr_n;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe or data wrong");
   property p_rd_float;
      !o_bus_rd_n |-> !o_bus_oe;
   endproperty
   a_rd_float: assert property (p_rd_float) else $error("bus driven during read");
   property p_rd_pulse;
      i_op_valid && (i_op == MMP_OP_BUS_READ || i_op == MMP_OP_EXT_READ) && o_bus_rd_n && o_bus_wr_n
         |=> !o_bus_rd_n [*2] ##1 o_bus_rd_n;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe missing");
   property p_add_carry;
      i_op_valid && i_op == MMP_OP_ALU && i_alu_fn == MMP_ALU_ADD && !i_status_write_en
         |=> o_acc == 8'($past(o_acc) + $past(i_operand))
         && o_status[STATUS_CARRY_BIT] == (9'($past(o_acc)) + 9'($past(i_operand)) > 9'h0ff);
   endproperty
   a_add_carry: assert property (p_add_carry) else $error("add result or carry wrong");
   property p_port_read;
      $stable(i_port_a_in) [*3] ##0 (i_op_valid && i_op == MMP_OP_PORT_READ && !i_port_sel)
         |=> o_acc == $past(i_port_a_in);
   endproperty
   a_port_read: assert property (p_port_read) else $error("port read not pin level");
   property p_ext_int;
      $fell(i_ext_int_n) && i_int_enable && !o_int_active |-> ##[1:10] o_pc == EXT_INT_VECTOR;
   endproperty
   a_ext_int: assert property (p_ext_int) else $error("interrupt vector not reached");
   c_wr: cover property ($fell(o_bus_wr_n));
   c_rd: cover property ($fell(o_bus_rd_n));
   c_int: cover property ($rose(o_int_active));
endmodule
bind mmp_core mmp_core_monitor mon_u (.i_clock, .i_rst, .i_op, .i_op_valid, .i_alu_fn, .i_operand,
   .i_status_write_en, .i_int_enable, .i_ext_int_n, .i_port_sel, .i_port_a_in, .o_port_a_out,
   .o_port_a_strong, .o_bus_out, .o_bus_oe, .o_bus_rd_n, .o_bus_wr_n, .o_acc, .o_status, .o_pc, .o_int_active);

//--- mmp_periph.sv
// partner: peripherals on the two ports and on the bus
`timescale 1ns/1ps
module mmp_periph (
   input wire logic i_clock,
   input wire logic [7:0] i_pa_latch,
   input wire logic [7:0] i_pb_latch,
   input wire logic [7:0] i_pa_low,
   input wire logic [7:0] i_pb_low,
   input wire logic [7:0] i_bus_out,
   input wire logic i_bus_oe,
   input wire logic i_bus_rd_n,
   input wire logic i_bus_wr_n,
   input wire logic [7:0] i_rd_value,
   output logic [7:0] o_pa_pin,
   output logic [7:0] o_pb_pin,
   output logic [7:0] o_bus_pin,
   output logic [7:0] o_captured
);
   logic [7:0] tog_q = 8'h5a;
   //////////////////////////////////////////////////////////////////////////////
   // weak pull-up lines, pulled low by an outside driver
   assign o_pa_pin = i_pa_latch & ~i_pa_low;
   assign o_pb_pin = i_pb_latch & ~i_pb_low;
   always_comb
   begin
      if (i_bus_oe)
         o_bus_pin = i_bus_out;
      else if (!i_bus_rd_n)
         o_bus_pin = i_rd_value;
      else
         o_bus_pin = tog_q;
   end
   always_ff @(posedge i_clock)
   begin
      tog_q <= ~tog_q;
      if (!i_bus_wr_n)
         o_captured <= o_bus_pin;
   end
endmodule

//--- mmp_core_tb.sv
// testbench: scenarios for the core against the pin model
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module mmp_core_tb;
   import mmp_pkg::*;
   int n_fail = 0;
   int n_tests = 0;
   logic i_clock = 0, i_rst = 1, i_op_valid = 0, i_select_value = 0, i_port_sel = 0, i_int_enable = 0;
   logic i_timer_int_enable = 0, i_ext_int_n = 1, i_timer_overflow = 0, i_status_write_en = 0;
   logic i_test_input_a = 0, i_test_input_b = 0, i_ptr_sel = 0, i_prog_load_en = 0;
   mmp_op_t i_op = MMP_OP_NONE;
   mmp_alu_t i_alu_fn = MMP_ALU_PASS;
   mmp_mem_t i_mem_op = MMP_MEM_NONE;
   logic [2:0] i_mem_index = 0;
   logic [11:0] i_target = 0, i_prog_load_addr = 0, o_pc;
   logic [7:0] i_operand = 0, i_status_write = 0, i_prog_load_data = 0, pa_low = 0, pb_low = 0, rd_value = 0;
   logic [7:0] pa_pin, pb_pin, bus_pin, captured, o_port_a_out, o_port_a_strong, o_port_b_out, o_port_b_strong;
   logic [7:0] o_bus_out, o_acc, o_status, o_mem_data, o_table_data;
   logic o_bus_oe, o_bus_rd_n, o_bus_wr_n, o_test_a, o_test_b, o_int_active, o_ext_int_level;
   //////////////////////////////////////////////////////////////////////////////
   mmp_core dut_u (.i_clock, .i_rst, .i_op, .i_op_valid, .i_alu_fn, .i_operand, .i_target, .i_select_value,
      .i_port_sel, .i_mem_op, .i_mem_index, .i_ptr_sel, .i_int_enable, .i_timer_int_enable, .i_ext_int_n,
      .i_timer_overflow, .i_status_write, .i_status_write_en, .i_prog_load_data, .i_prog_load_addr,
      .i_prog_load_en, .i_port_a_in(pa_pin), .o_port_a_out, .o_port_a_strong, .i_port_b_in(pb_pin),
      .o_port_b_out, .o_port_b_strong, .i_bus_in(bus_pin), .o_bus_out, .o_bus_oe, .o_bus_rd_n, .o_bus_wr_n,
      .i_test_input_a, .i_test_input_b, .o_test_a, .o_test_b, .o_ext_int_level, .o_acc, .o_status, .o_pc,
      .o_mem_data, .o_table_data, .o_int_active);
   mmp_periph pm_u (.i_clock, .i_pa_latch(o_port_a_out), .i_pb_latch(o_port_b_out), .i_pa_low(pa_low),
      .i_pb_low(pb_low), .i_bus_out(o_bus_out), .i_bus_oe(o_bus_oe), .i_bus_rd_n(o_bus_rd_n),
      .i_bus_wr_n(o_bus_wr_n), .i_rd_value(rd_value), .o_pa_pin(pa_pin), .o_pb_pin(pb_pin),
      .o_bus_pin(bus_pin), .o_captured(captured));
   //////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask
   task automatic op(input mmp_op_t o, input mmp_alu_t f, input logic [7:0] d, input mmp_mem_t m);
      @(posedge i_clock);
      i_op <= o;
      i_alu_fn <= f;
      i_operand <= d;
      i_mem_op <= m;
      i_op_valid <= 1'b1;
      @(posedge i_clock);
      i_op_valid <= 1'b0;
      tick(1);
   endtask
   task automatic ld(input logic [7:0] v);
      op(MMP_OP_ALU, MMP_ALU_PASS, v, MMP_MEM_NONE);
   endtask
   task automatic final_report();
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      `CHK(o_pc, RESET_VECTOR)
      `CHK(o_status, STATUS_RESET)
      `CHK({o_port_a_out, o_port_b_out, o_port_a_strong, o_port_b_strong}, {PORT_RESET, PORT_RESET, 16'h0000})
      `CHK({o_bus_oe, o_bus_rd_n, o_bus_wr_n}, 3'b011)
   endtask
   task automatic t_alu();
      mmp_alu_t fn [10] = '{MMP_ALU_ADD, MMP_ALU_AND, MMP_ALU_OR, MMP_ALU_XOR, MMP_ALU_INC,
         MMP_ALU_DEC, MMP_ALU_CPL, MMP_ALU_RL, MMP_ALU_RR, MMP_ALU_SWAP};
      logic [7:0] ex [10] = '{8'h12, 8'h48, 8'hca, 8'h82, 8'hc9, 8'hc7, 8'h37, 8'h91, 8'h64, 8'h8c};
      for (int k = 0; k < 10; k++)
      begin
         ld(8'hc8);
         op(MMP_OP_ALU, fn[k], 8'h4a, MMP_MEM_NONE);
         `CHK(o_acc, ex[k])
      end
      ld(8'hc8);
      op(MMP_OP_ALU, MMP_ALU_ADD, 8'h38, MMP_MEM_NONE);
      `CHK({o_status[STATUS_CARRY_BIT], o_acc}, 9'h100)
      op(MMP_OP_ALU, MMP_ALU_ADDC, 8'h37, MMP_MEM_NONE);
      `CHK({o_status[STATUS_CARRY_BIT], o_acc}, 9'h038)
   endtask
   task automatic t_bank();
      @(posedge i_clock);
      i_mem_index <= 3'd2;
      i_select_value <= 1'b1;
      ld(8'h11);
      op(MMP_OP_NONE, MMP_ALU_PASS, 8'h11, MMP_MEM_WORK_WR);
      op(MMP_OP_SELECT_BANK, MMP_ALU_PASS, 8'h00, MMP_MEM_NONE);
      `CHK(o_status[STATUS_BANK_BIT], 1'b1)
      ld(8'h22);
      op(MMP_OP_NONE, MMP_ALU_PASS, 8'h22, MMP_MEM_WORK_WR);
      op(MMP_OP_NONE, MMP_ALU_PASS, 8'h00, MMP_MEM_WORK_RD);
      `CHK(o_mem_data, 8'h22)
      @(posedge i_clock);
      i_status_write_en <= 1'b1;
      @(posedge i_clock);
      i_status_write_en <= 1'b0;
      tick(1);
      `CHK(o_status, STATUS_RESET)
      op(MMP_OP_NONE, MMP_ALU_PASS, 8'h00, MMP_MEM_WORK_RD);
      `CHK(o_mem_data, 8'h11)
   endtask
   task automatic t_ports();
      ld(8'h0f);
      op(MMP_OP_PORT_WRITE, MMP_ALU_PASS, 8'h0f, MMP_MEM_NONE);
      `CHK({o_port_a_out, o_port_a_strong}, 16'h0f0f)
      @(posedge i_clock);
      pa_low <= 8'h01;
      i_test_input_a <= 1'b1;
      tick(3);
      `CHK({o_port_a_strong, o_test_a, o_test_b}, 10'b10)
      op(MMP_OP_PORT_OR, MMP_ALU_PASS, 8'h30, MMP_MEM_NONE);
      `CHK({o_port_a_out, o_port_a_strong}, 16'h3e3e)
      @(posedge i_clock);
      pa_low <= 8'h03;
      tick(3);
      op(MMP_OP_PORT_READ, MMP_ALU_PASS, 8'h00, MMP_MEM_NONE);
      `CHK(o_acc, 8'h3c)
      @(posedge i_clock);
      i_port_sel <= 1'b1;
      pb_low <= 8'h10;
      tick(3);
      op(MMP_OP_PORT_AND, MMP_ALU_PASS, 8'hf0, MMP_MEM_NONE);
      `CHK({o_port_b_out, o_port_b_strong}, 16'he0e0)
   endtask
   task automatic t_bus();
      ld(8'h3c);
      op(MMP_OP_BUS_WRITE, MMP_ALU_PASS, 8'h3c, MMP_MEM_NONE);
      tick(3);
      `CHK({captured, o_bus_out, o_bus_oe}, {8'h3c, 8'h3c, 1'b1})
      rd_value <= 8'ha7;
      op(MMP_OP_BUS_READ, MMP_ALU_PASS, 8'h00, MMP_MEM_NONE);
      tick(4);
      `CHK({o_acc, o_bus_oe}, {8'ha7, 1'b0})
      ld(8'h5a);
      op(MMP_OP_EXT_WRITE, MMP_ALU_PASS, 8'h5a, MMP_MEM_NONE);
      tick(3);
      `CHK({captured, o_bus_oe}, {8'h5a, 1'b0})
      rd_value <= 8'h96;
      op(MMP_OP_EXT_READ, MMP_ALU_PASS, 8'h00, MMP_MEM_NONE);
      tick(4);
      `CHK(o_acc, 8'h96)
   endtask
   task automatic t_int();
      @(posedge i_clock);
      i_target <= 12'h123;
      i_prog_load_addr <= 12'h996;
      i_prog_load_data <= 8'hc3;
      i_prog_load_en <= 1'b1;
      op(MMP_OP_SELECT_MB, MMP_ALU_PASS, 8'h00, MMP_MEM_NONE);
      op(MMP_OP_JUMP, MMP_ALU_PASS, 8'h00, MMP_MEM_NONE);
      `CHK(o_pc, 12'h923)
      op(MMP_OP_NONE, MMP_ALU_PASS, 8'h00, MMP_MEM_TABLE);
      `CHK(o_table_data, 8'hc3)
      @(posedge i_clock);
      i_prog_load_en <= 1'b0;
      i_int_enable <= 1'b1;
      i_ext_int_n <= 1'b0;
      for (int k = 0; k < 12; k++)
         if (o_pc !== EXT_INT_VECTOR)
            tick(1);
      `CHK({o_pc, o_int_active, o_status[2:0], o_ext_int_level}, {EXT_INT_VECTOR, 1'b1, 3'h1, 1'b1})
      @(posedge i_clock);
      i_ext_int_n <= 1'b1;
      i_timer_int_enable <= 1'b1;
      i_mem_index <= 3'd0;
      ld(8'h08);
      op(MMP_OP_NONE, MMP_ALU_PASS, 8'h00, MMP_MEM_WORK_WR);
      op(MMP_OP_NONE, MMP_ALU_PASS, 8'h00, MMP_MEM_IND_RD);
      `CHK(o_mem_data, 8'h24)
      op(MMP_OP_RETR, MMP_ALU_PASS, 8'h00, MMP_MEM_NONE);
      @(posedge i_clock);
      i_timer_overflow <= 1'b1;
      @(posedge i_clock);
      i_timer_overflow <= 1'b0;
      for (int k = 0; k < 12; k++)
         if (o_pc !== TIMER_INT_VECTOR)
            tick(1);
      `CHK(o_pc, TIMER_INT_VECTOR)
   endtask
   //////////////////////////////////////////////////////////////////////////////
   initial
   begin
      forever #25 i_clock = ~i_clock;
   end
   initial
   begin
      #100us;
      n_fail++;
      final_report();
   end
   initial
   begin
      repeat (6) @(posedge i_clock);
      t_reset();
      i_rst <= 1'b0;
      t_alu();
      t_bank();
      t_ports();
      t_bus();
      t_int();
      final_report();
   end
endmodule
